// File: include/coherent_fabric_params.svh
/*
  Register offsets, field positions and reset values for the coherent
  fabric control and status register bank.
  Assumes a 12-bit APB byte address and 32-bit data.
*/
// Functional notes
// - Suppress speculation if slave or master disables
// - Slave disable bits [20:16], reset zero
// - Master disable bits [2:0], reset zero
// - Non-secure speculation access needs grant bit
// - Grant register writable by secure only
// - Grant bit zero resets low, permits non-secure
// - Pending while enable change not applied
// - Pending while disabled port has outstanding snoops
// - Pending is status bit zero, read-only
// - Imprecise error sets per-interface sticky bit
// - Slave error bits at [20:16]
// - Master error bits at [2:0]
// - Writing one clears an error bit
// - Active-low fault interrupt while any error
// - Error register secure unless grant set
// - Global override disables all master speculation
`ifndef COHERENT_FABRIC_PARAMS_SVH
`define COHERENT_FABRIC_PARAMS_SVH

`define CF_OFF_SPEC 12'h000
`define CF_OFF_GRANT 12'h004
`define CF_OFF_STATUS 12'h008
`define CF_OFF_ERR 12'h00C
`define CF_OFF_OVRD 12'h010
`define CF_OFF_IRQ_STAT 12'h014
`define CF_OFF_IRQ_EN 12'h018
`define CF_OFF_IRQ_CLR 12'h01C

`define CF_SLV_LSB 16
`define CF_SLV_MSB 20
`define CF_MST_LSB 0
`define CF_MST_MSB 2
`define CF_GRANT_BIT 0
`define CF_PEND_BIT 0
`define CF_OVRD_SPEC_BIT 2
`define CF_IRQ_ERR_BIT 0
`define CF_IRQ_APPLIED_BIT 1
`define CF_PROT_NS_BIT 1

`define CF_RST_MASK 8'h00
`define CF_RST_GRANT 1'b0
`define CF_RST_IRQ 2'h0

`endif

// File: include/coherent_fabric_pkg.sv
/*
  Shared types for the coherent fabric register bank.
  Assumes five slave and three master interfaces.
*/
package coherent_fabric_pkg;

  typedef struct packed {
    logic [4:0] slave;
    logic [2:0] master;
  } port_mask_t;

  typedef struct packed {
    logic valid;
    logic [2:0] slave;
    logic [1:0] master;
  } spec_query_t;

endpackage

// File: src/coherent_fabric_ctrl_status_regs.sv
/*
  APB register bank: speculation gating, non-secure grant, enable update
  status, deferred error flags and interrupts.
  Assumes partner logic on sys_clk; pprot[1] high marks non-secure.
*/
`timescale 1ns/1ps
`include "coherent_fabric_params.svh"

module coherent_fabric_ctrl_status_regs #(
  parameter int ADDR_W = 12
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [2:0] pprot,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic snoopChangeInFlight,
  input wire logic [4:0] snoopPortDisabled,
  input wire logic [4:0] snoopPortOutstanding,
  input wire coherent_fabric_pkg::port_mask_t impreciseErr,
  input wire coherent_fabric_pkg::spec_query_t specQuery,
  output logic specRespValid,
  output logic specSuppress,
  output coherent_fabric_pkg::port_mask_t specDisabled,
  output logic fault_interrupt_low,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // Decode

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [11:0] off);
    hit = (32'(a) == 32'(off));
  endfunction

  function automatic coherent_fabric_pkg::port_mask_t fieldsOf(
      input logic [31:0] w);
    fieldsOf.slave = w[`CF_SLV_MSB:`CF_SLV_LSB];
    fieldsOf.master = w[`CF_MST_MSB:`CF_MST_LSB];
  endfunction

  function automatic logic [31:0] wordOf(
      input coherent_fabric_pkg::port_mask_t m);
    wordOf = 32'h0000_0000;
    wordOf[`CF_SLV_MSB:`CF_SLV_LSB] = m.slave;
    wordOf[`CF_MST_MSB:`CF_MST_LSB] = m.master;
  endfunction

  function automatic logic offAt(input logic [4:0] v,
                                 input logic [2:0] i);
    offAt = 1'b1;
    for (int j = 0; j < 5; j++) begin
      if (i == 3'(j)) offAt = v[j];
    end
  endfunction

  coherent_fabric_pkg::port_mask_t specMask_q, specMask_d;
  coherent_fabric_pkg::port_mask_t errFlags_q, errFlags_d;
  coherent_fabric_pkg::port_mask_t specDis_q, specDis_d;
  logic grant_q, grant_d;
  logic ovrdSpec_q, ovrdSpec_d;
  logic pending_q, pending_d;
  logic [1:0] irqStat_q, irqStat_d, irqEn_q, irqEn_d;
  logic ready_q, ready_d, slvErr_q, slvErr_d;
  logic [31:0] rdata_q, rdata_d;
  logic irq_q, irq_d, fault_q, fault_d;
  logic respValid_q, suppress_q, suppress_d;

  wire logic nonSecure = pprot[`CF_PROT_NS_BIT];
  // Grant opens non-secure access to every gated register at once
  wire logic nsOk = ~nonSecure | grant_q;
  wire logic access = psel & penable;
  // One wait state keeps pready and prdata on flops
  wire logic accept = access & ready_q;

  wire logic hitSpec = hit(paddr, `CF_OFF_SPEC);
  wire logic hitGrant = hit(paddr, `CF_OFF_GRANT);
  wire logic hitStatus = hit(paddr, `CF_OFF_STATUS);
  wire logic hitErr = hit(paddr, `CF_OFF_ERR);
  wire logic hitOvrd = hit(paddr, `CF_OFF_OVRD);
  wire logic hitIrqStat = hit(paddr, `CF_OFF_IRQ_STAT);
  wire logic hitIrqEn = hit(paddr, `CF_OFF_IRQ_EN);
  wire logic hitIrqClr = hit(paddr, `CF_OFF_IRQ_CLR);
  wire logic mapped = hitSpec | hitGrant | hitStatus | hitErr | hitOvrd |
                      hitIrqStat | hitIrqEn | hitIrqClr;

  // Denied: unmapped, gated without grant, any non-secure override access, non-secure grant writes
  wire logic denied = ~mapped |
                      ((hitSpec | hitErr | hitIrqEn | hitIrqClr |
                        hitIrqStat) & ~nsOk) |
                      (hitOvrd & nonSecure) |
                      (hitGrant & pwrite & nonSecure);

  wire logic [31:0] byteMask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                                {8{pstrb[1]}}, {8{pstrb[0]}}};
  wire logic [31:0] wmask = pwdata & byteMask;
  wire logic wrOk = accept & pwrite & ~denied;

  ////////////////////////////////////////////////////////////////////////
  // Control registers

  // Only defined field bits are stored; reserved bits never hold state
  wire coherent_fabric_pkg::port_mask_t specKeep = fieldsOf(~byteMask);
  wire coherent_fabric_pkg::port_mask_t specNew = fieldsOf(wmask);
  assign specMask_d = (wrOk && hitSpec) ?
                      ((specMask_q & specKeep) | specNew) :
                      specMask_q;
  assign grant_d = (wrOk && hitGrant && pstrb[0]) ?
                   pwdata[`CF_GRANT_BIT] : grant_q;
  assign ovrdSpec_d = (wrOk && hitOvrd && pstrb[0]) ?
                      pwdata[`CF_OVRD_SPEC_BIT] : ovrdSpec_q;
  assign irqEn_d = (wrOk && hitIrqEn && pstrb[0]) ?
                   pwdata[1:0] : irqEn_q;

  ////////////////////////////////////////////////////////////////////////
  // Status and errors

  // Write to status is accepted but has no effect
  assign pending_d = snoopChangeInFlight |
                     |(snoopPortDisabled & snoopPortOutstanding);

  wire coherent_fabric_pkg::port_mask_t errClr =
      (wrOk && hitErr) ? fieldsOf(wmask) : '0;
  // New error beats a clearing write in the same cycle
  assign errFlags_d = (errFlags_q & ~errClr) | impreciseErr;
  assign fault_d = ~|errFlags_d;

  wire logic [1:0] irqEvt = {pending_q & ~pending_d, |impreciseErr};
  wire logic [1:0] irqClr = (wrOk && hitIrqClr && pstrb[0]) ?
                            pwdata[1:0] : 2'h0;
  assign irqStat_d = (irqStat_q & ~irqClr) | irqEvt;
  assign irq_d = |(irqStat_d & irqEn_d);

  ////////////////////////////////////////////////////////////////////////
  // Speculation gating

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : gMaster
      assign specDis_d.master[gi] = specMask_d.master[gi] |
                                    ovrdSpec_d;
    end
  endgenerate
  assign specDis_d.slave = specMask_d.slave;

  // Out-of-range port numbers read as disabled, so queries fail safe
  wire logic slvOff = offAt(specDis_q.slave, specQuery.slave);
  wire logic mstOff = offAt({2'h3, specDis_q.master},
                            {1'h0, specQuery.master});
  assign suppress_d = specQuery.valid & (slvOff | mstOff);

  ////////////////////////////////////////////////////////////////////////
  // Read path

  wire logic [31:0] readMux =
      hitSpec ? wordOf(specMask_q) :
      hitGrant ? {31'h0, grant_q} :
      hitStatus ? {31'h0, pending_q} :
      hitErr ? wordOf(errFlags_q) :
      hitOvrd ? {29'h0, ovrdSpec_q, 2'h0} :
      hitIrqStat ? {30'h0, irqStat_q} :
      hitIrqEn ? {30'h0, irqEn_q} : 32'h0000_0000;

  assign ready_d = access & ~ready_q;
  assign slvErr_d = ready_d & denied;
  assign rdata_d = (ready_d & ~pwrite & ~denied) ? readMux : 32'h0;

  ////////////////////////////////////////////////////////////////////////
  // Flops

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      specMask_q <= `CF_RST_MASK;
      errFlags_q <= `CF_RST_MASK;
      specDis_q <= `CF_RST_MASK;
      grant_q <= `CF_RST_GRANT;
      ovrdSpec_q <= 1'b0;
      pending_q <= 1'b0;
      irqStat_q <= `CF_RST_IRQ;
      irqEn_q <= `CF_RST_IRQ;
    end else begin
      specMask_q <= specMask_d;
      errFlags_q <= errFlags_d;
      specDis_q <= specDis_d;
      grant_q <= grant_d;
      ovrdSpec_q <= ovrdSpec_d;
      pending_q <= pending_d;
      irqStat_q <= irqStat_d;
      irqEn_q <= irqEn_d;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ready_q <= 1'b0;
      slvErr_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      irq_q <= 1'b0;
      fault_q <= 1'b1;
      respValid_q <= 1'b0;
      suppress_q <= 1'b0;
    end else begin
      ready_q <= ready_d;
      slvErr_q <= slvErr_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      fault_q <= fault_d;
      respValid_q <= specQuery.valid;
      suppress_q <= suppress_d;
    end
  end

  assign pready = ready_q;
  assign pslverr = slvErr_q;
  assign prdata = rdata_q;
  assign irq = irq_q;
  assign fault_interrupt_low = fault_q;
  assign specRespValid = respValid_q;
  assign specSuppress = suppress_q;
  assign specDisabled = specDis_q;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  a_spec_gate_either: assert property (
    specQuery.valid && specQuery.slave <= 3'h4 &&
    specQuery.master <= 2'h2 &&
    !specDis_q.slave[specQuery.slave] &&
    !specDis_q.master[specQuery.master]
    |=> specRespValid && !specSuppress)
    else $error("speculation suppressed while both ports enabled");

  a_spec_slave_off: assert property (
    specQuery.valid && specQuery.slave <= 3'h4 &&
    specMask_q.slave[specQuery.slave] |=> specSuppress)
    else $error("disabled slave port did not suppress speculation");

  a_ns_spec_block: assert property (
    accept && pwrite && hitSpec && nonSecure && !grant_q |->
      pslverr ##1 $stable(specMask_q))
    else $error("non-secure speculation write taken without grant");

  a_grant_secure: assert property (
    accept && pwrite && hitGrant && nonSecure |=> $stable(grant_q))
    else $error("non-secure write changed grant");

  a_pending_track: assert property (
    ##1 pending_q == $past(snoopChangeInFlight ||
      |(snoopPortDisabled & snoopPortOutstanding)))
    else $error("pending bit does not follow outstanding changes");

  a_pending_ro: assert property (
    accept && pwrite && hitStatus && !pending_d |=> !pending_q)
    else $error("status write altered pending bit");

  a_err_sticky: assert property (
    |impreciseErr |=> (errFlags_q & $past(impreciseErr)) ==
      $past(impreciseErr) && fault_interrupt_low == 1'b0)
    else $error("error flag or interrupt missing after error");

  a_err_w1c: assert property (
    wrOk && hitErr && impreciseErr == '0 |=>
      errFlags_q == ($past(errFlags_q) & ~fieldsOf($past(wmask))))
    else $error("write-one-to-clear result wrong");

  a_irq_level: assert property (
    fault_interrupt_low == (errFlags_q == '0))
    else $error("fault interrupt level disagrees with flags");

  a_err_ns_deny: assert property (
    accept && pwrite && hitErr && nonSecure && !grant_q &&
    impreciseErr == '0 |-> pslverr ##1 $stable(errFlags_q))
    else $error("non-secure error write not refused");

  a_ovrd_all: assert property (
    ovrdSpec_q |-> specDisabled.master == 3'h7)
    else $error("override did not disable all masters");

  a_reserved_zero: assert property (
    pready |-> prdata[31:21] == 11'h000 && prdata[15:3] == 13'h0000)
    else $error("reserved read bits not zero");

  a_set_wins: assert property (
    wrOk && hitErr && impreciseErr.master[0] |=> errFlags_q.master[0])
    else $error("clear beat a new error");

  a_ready_one_wait: assert property (
    access && !pready |=> pready ##1 !pready)
    else $error("pready not one cycle after one wait state");

  a_spec_master_off: assert property (
    specQuery.valid && specQuery.master <= 2'h2 &&
    specDis_q.master[specQuery.master] |=> specSuppress)
    else $error("disabled master port did not suppress speculation");

  a_resp_follow: assert property (
    specQuery.valid |=> specRespValid)
    else $error("speculation answer missing after query");

  a_resp_idle: assert property (
    !specQuery.valid |=> !specRespValid)
    else $error("speculation answer without query");

  a_slverr_ready: assert property (
    pslverr |-> pready)
    else $error("pslverr outside the answer cycle");

  a_ready_pulse: assert property (
    pready |=> !pready)
    else $error("pready held longer than one cycle");

  a_err_data_zero: assert property (
    pslverr |-> prdata == 32'h0000_0000)
    else $error("refused access returned data");

  a_grant_set: assert property (
    accept && pwrite && hitGrant && !nonSecure && pstrb[0] |=>
      grant_q == $past(pwdata[0]))
    else $error("secure grant write did not land");

  a_ns_grant_err: assert property (
    accept && pwrite && hitGrant && nonSecure |-> pslverr)
    else $error("non-secure grant write not refused");

  a_ns_err_open: assert property (
    accept && hitErr && nonSecure && grant_q |-> !pslverr)
    else $error("granted non-secure error access refused");

  a_ns_spec_open: assert property (
    accept && hitSpec && nonSecure && grant_q |-> !pslverr)
    else $error("granted non-secure speculation access refused");

  a_status_open: assert property (
    accept && hitStatus |-> !pslverr)
    else $error("status access refused");

  a_status_read: assert property (
    accept && hitStatus && !pwrite |-> prdata == {31'h0, $past(pending_q)})
    else $error("status read disagrees with pending bit");

  a_irq_masked: assert property (
    irqEn_q == 2'h0 |-> !irq)
    else $error("interrupt raised with all sources masked");

  a_spec_keep: assert property (
    !(wrOk && hitSpec) |=> $stable(specMask_q))
    else $error("speculation mask changed without a write");

  a_grant_keep: assert property (
    !(wrOk && hitGrant) |=> $stable(grant_q))
    else $error("grant changed without an accepted write");

  a_err_only_set: assert property (
    impreciseErr == '0 |=> (errFlags_q & ~$past(errFlags_q)) == '0)
    else $error("error flag set without an error");

  a_pending_zero: assert property (
    !snoopChangeInFlight && (snoopPortDisabled & snoopPortOutstanding) ==
      5'h00 |=> !pending_q)
    else $error("pending bit set with nothing outstanding");

  c_set_beats_clear: cover property (wrOk && hitErr && |impreciseErr);
  c_ns_denied: cover property (accept && denied && nonSecure);
  c_err_clear: cover property (wrOk && hitErr && |errFlags_q);
  c_spec_suppress: cover property (specRespValid && specSuppress);
  c_pending_fall: cover property (pending_q ##1 !pending_q);

endmodule // coherent_fabric_ctrl_status_regs

// File: testbench/fabric_side_model.sv
/*
  Far-side model: interface and snoop logic of the fabric.
  Assumes calls come just after a rising edge of sys_clk.
*/
`timescale 1ns/1ps
module fabric_side_model (
  input wire logic sys_clk,
  input wire logic specRespValid,
  input wire logic specSuppress,
  output logic snoopChangeInFlight,
  output logic [4:0] snoopPortDisabled,
  output logic [4:0] snoopPortOutstanding,
  output coherent_fabric_pkg::port_mask_t impreciseErr,
  output coherent_fabric_pkg::spec_query_t specQuery
);
  initial begin
    snoopChangeInFlight = 1'b0;
    snoopPortDisabled = 5'h00;
    snoopPortOutstanding = 5'h00;
    impreciseErr = 8'h00;
    specQuery = 6'h00;
  end
  //////////////////////////////////////////////////////////////////////////
  // Snoop state stays as a level until changed
  task automatic pend(input logic f, input logic [4:0] d,
                      input logic [4:0] o);
    snoopChangeInFlight <= f;
    snoopPortDisabled <= d;
    snoopPortOutstanding <= o;
    @(posedge sys_clk);
  endtask
  // One-cycle pulse; idle edge after it so calls may follow at once
  task automatic err(input logic [7:0] m);
    impreciseErr <= m;
    @(posedge sys_clk);
    impreciseErr <= 8'h00;
    @(posedge sys_clk);
  endtask
  task automatic ask(input logic [2:0] s, input logic [1:0] m,
                     output logic [1:0] r);
    specQuery <= {1'b1, s, m};
    @(posedge sys_clk);
    specQuery <= 6'h00;
    @(posedge sys_clk);
    r = {specRespValid, specSuppress};
  endtask
endmodule // fabric_side_model

// File: testbench/coherent_fabric_ctrl_status_regs_tb_top.sv
/*
  Testbench: APB master tasks and directed register sequences.
  Assumes the design answers within a few cycles; model drives far side.
*/
`timescale 1ns/1ps
`include "coherent_fabric_params.svh"
module coherent_fabric_ctrl_status_regs_tb_top;
  logic sys_clk, resetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [3:0] pstrb;
  logic [2:0] pprot;
  logic snoopChangeInFlight, specRespValid, specSuppress;
  logic fault_interrupt_low, irq;
  logic [4:0] snoopPortDisabled, snoopPortOutstanding;
  coherent_fabric_pkg::port_mask_t impreciseErr, specDisabled;
  coherent_fabric_pkg::spec_query_t specQuery;
  logic [1:0] ans;
  int failures = 0;
  int comparisons = 0;
  int k;
  coherent_fabric_ctrl_status_regs dut (.sys_clk, .resetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .pprot, .pready, .prdata,
    .pslverr, .snoopChangeInFlight, .snoopPortDisabled,
    .snoopPortOutstanding, .impreciseErr, .specQuery, .specRespValid,
    .specSuppress, .specDisabled, .fault_interrupt_low, .irq);
  fabric_side_model pm (.sys_clk, .specRespValid, .specSuppress,
    .snoopChangeInFlight, .snoopPortDisabled, .snoopPortOutstanding,
    .impreciseErr, .specQuery);
  always #12.5 sys_clk = ~sys_clk;
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, x, s);
    end
  endtask
  // Held until pready; one idle edge after so no signal is set twice
  task automatic apb(input logic w, input logic ns, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pprot <= {1'b0, ns, 1'b0};
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    rdv = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
    if (n >= 40) failures++;
  endtask
  task automatic acc(input logic w, input logic ns, input logic [11:0] a,
                     input logic [31:0] d, input logic [31:0] x,
                     input logic xe);
    apb(w, ns, a, d);
    chk($sformatf("pslverr@%h", a), e, xe);
    if (!w) chk($sformatf("prdata@%h", a), rdv, x);
  endtask
  task automatic results;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #150000;
    failures++;
    results();
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    {sys_clk, resetn, psel, penable, pwrite} = 5'h00;
    {paddr, pwdata, pprot} = 47'h0;
    pstrb = 4'hF;
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    chk("fault", fault_interrupt_low, 1);
    acc(0, 0, `CF_OFF_SPEC, 0, 0, 0);
    acc(0, 0, `CF_OFF_GRANT, 0, 0, 0);
    acc(0, 0, `CF_OFF_STATUS, 0, 0, 0);
    acc(0, 0, `CF_OFF_ERR, 0, 0, 0);
    acc(1, 0, `CF_OFF_SPEC, 32'hFFFFFFFF, 0, 0);
    acc(0, 0, `CF_OFF_SPEC, 0, 32'h001F0007, 0);
    // Slave 1 and master 0 gated
    acc(1, 0, `CF_OFF_SPEC, 32'h00020001, 0, 0);
    pm.ask(3'h1, 2'h1, ans);
    chk("s1m1", ans, 2'h3);
    pm.ask(3'h0, 2'h0, ans);
    chk("s0m0", ans, 2'h3);
    pm.ask(3'h4, 2'h2, ans);
    chk("s4m2", ans, 2'h2);
    acc(1, 0, `CF_OFF_OVRD, 32'h4, 0, 0);
    chk("specDis", specDisabled, 8'h17);
    pm.ask(3'h4, 2'h2, ans);
    chk("ovrd", ans, 2'h3);
    acc(1, 0, `CF_OFF_OVRD, 0, 0, 0);
    // Non-secure refused while grant is low
    acc(1, 1, `CF_OFF_SPEC, 0, 0, 1);
    acc(0, 0, `CF_OFF_SPEC, 0, 32'h00020001, 0);
    acc(1, 1, `CF_OFF_GRANT, 1, 0, 1);
    acc(0, 0, `CF_OFF_GRANT, 0, 0, 0);
    acc(0, 1, `CF_OFF_ERR, 0, 0, 1);
    acc(1, 0, `CF_OFF_GRANT, 32'hFFFFFFFF, 0, 0);
    acc(0, 0, `CF_OFF_GRANT, 0, 1, 0);
    acc(1, 1, `CF_OFF_SPEC, 0, 0, 0);
    acc(0, 1, `CF_OFF_SPEC, 0, 0, 0);
    acc(0, 1, `CF_OFF_ERR, 0, 0, 0);
    acc(1, 0, `CF_OFF_GRANT, 0, 0, 0);
    acc(0, 0, 12'h020, 0, 0, 1);
    // Pending status
    pm.pend(1, 5'h00, 5'h00);
    acc(0, 0, `CF_OFF_STATUS, 0, 1, 0);
    pm.pend(0, 5'h04, 5'h04);
    acc(0, 0, `CF_OFF_STATUS, 0, 1, 0);
    pm.pend(0, 5'h00, 5'h00);
    k = 0;
    do begin
      apb(0, 0, `CF_OFF_STATUS, 0);
      k++;
    end while (rdv[0] !== 1'b0 && k < 8);
    chk("settled", rdv, 0);
    acc(1, 0, `CF_OFF_STATUS, 32'hFFFFFFFF, 0, 0);
    acc(0, 0, `CF_OFF_STATUS, 0, 0, 0);
    // Errors: slave 4 and master 0, then interrupt path
    acc(1, 0, `CF_OFF_IRQ_CLR, 32'h3, 0, 0);
    acc(1, 0, `CF_OFF_IRQ_EN, 32'h1, 0, 0);
    pm.err(8'h81);
    repeat (2) @(posedge sys_clk);
    chk("fault", fault_interrupt_low, 0);
    chk("irq", irq, 1);
    acc(0, 0, `CF_OFF_ERR, 0, 32'h00100001, 0);
    acc(1, 1, `CF_OFF_ERR, 32'h00100001, 0, 1);
    acc(1, 0, `CF_OFF_ERR, 0, 0, 0);
    acc(0, 0, `CF_OFF_ERR, 0, 32'h00100001, 0);
    acc(1, 0, `CF_OFF_ERR, 32'h1, 0, 0);
    acc(0, 0, `CF_OFF_ERR, 0, 32'h00100000, 0);
    acc(1, 0, `CF_OFF_IRQ_CLR, 32'h1, 0, 0);
    chk("irq", irq, 0);
    acc(1, 0, `CF_OFF_ERR, 32'h00100000, 0, 0);
    chk("fault", fault_interrupt_low, 1);
    // Masked event still latches
    acc(1, 0, `CF_OFF_IRQ_EN, 0, 0, 0);
    pm.err(8'h02);
    repeat (2) @(posedge sys_clk);
    chk("irq", irq, 0);
    apb(0, 0, `CF_OFF_IRQ_STAT, 0);
    chk("stat", rdv[0], 1);
    acc(0, 0, `CF_OFF_ERR, 0, 32'h2, 0);
    // Error pulse lands on the edge that takes the clearing write
    fork
      acc(1, 0, `CF_OFF_ERR, 32'h1, 0, 0);
      begin
        repeat (2) @(posedge sys_clk);
        pm.err(8'h01);
      end
    join
    acc(0, 0, `CF_OFF_ERR, 0, 32'h3, 0);
    results();
  end
endmodule // coherent_fabric_ctrl_status_regs_tb_top
